// ---- rsc_params.svh ----
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_CLK_PERIOD_NS 100
`define RSC_DWELL_UNIT_NS 100000
`define RSC_UNIT_CYCLES ((`RSC_DWELL_UNIT_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_DWELL_RST 16'h0000
`define RSC_MAT_ROWS 4
`define RSC_MAT_COLS 16
`define RSC_SEC_SIZE 16
`define RSC_NAME_M 8'h6d
`define RSC_DIGIT_1 8'h31
`define RSC_SRC_LSB 0
`define RSC_LINE_LSB 2
`endif

// ---- rsc_pkg.sv ----
package rsc_pkg;
	typedef enum logic [4:0] {
		CMD_NOP, CMD_CLOSE, CMD_CLOSE_Q, CMD_SCAN, CMD_ALIAS, CMD_ABORT,
		CMD_INIT, CMD_SOURCE, CMD_FORCE, CMD_BUS_TRIG,
		CMD_COMMON_TRIGGER_COMMAND, CMD_DELAY, CMD_OPEN_DWELL,
		CMD_CLOSE_DWELL, CMD_TTL_OUT, CMD_RESET, CMD_CLR_ERR
	} rsc_cmd_type;
	typedef enum logic [1:0] {SRC_IMM, SRC_NONE, SRC_BUS, SRC_TTL} rsc_src_type;
	typedef enum logic [1:0] {W_IDLE, W_RUN, W_SETTLE} rsc_walk_type;
	typedef enum logic [2:0] {
		S_IDLE, S_ARMED, S_DELAY, S_OPEN, S_OPEN_WAIT, S_CLOSE, S_CLOSE_WAIT
	} rsc_scan_type;
endpackage : rsc_pkg

// ---- rsc_dwell_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"
module rsc_dwell_timer #(
	parameter int UNIT = `RSC_UNIT_CYCLES,
	parameter int VW = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic start,
	input wire logic cancel,
	input wire logic [VW-1:0] load,
	// result
	output logic done
);
	localparam int DW = (UNIT > 1) ? $clog2(UNIT) : 1;
	localparam logic [DW-1:0] RELOAD = DW'(UNIT - 1);
	typedef struct packed {
		logic run;
		logic done;
		logic [VW-1:0] count;
		logic [DW-1:0] div;
	} rsc_tmr_type;
	rsc_tmr_type st, next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (cancel) begin
			next_st.run = 1'b0;
		end else if (start) begin
			// a zero setting still answers, one cycle later
			if (load == '0) begin
				next_st.done = 1'b1;
			end else begin
				next_st.run = 1'b1;
				next_st.count = load;
				next_st.div = RELOAD;
			end
		end else if (st.run) begin
			if (st.div == '0) begin
				next_st.div = RELOAD;
				next_st.count = st.count - 1'b1;
				if (st.count == 1) begin
					next_st.run = 1'b0;
					next_st.done = 1'b1;
				end
			end else begin
				next_st.div = st.div - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;

	chk_zero_done: assert property (@(posedge clk) disable iff (srst)
		start && !cancel && load == '0 |=> done)
		else $error("zero setting gave no done");
endmodule : rsc_dwell_timer
`default_nettype wire

// ---- rsc_scan_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"
module rsc_scan_ctrl
	import rsc_pkg::*;
#(
	parameter int NMOD = 4,
	parameter int NREL = 256,
	parameter int DEPTH = 16,
	parameter int FW = 9,
	parameter int ROWS = `RSC_MAT_ROWS,
	parameter int COLS = `RSC_MAT_COLS,
	parameter int SEC = `RSC_SEC_SIZE,
	parameter logic [2*NMOD-1:0] MOD_DIMS = 8'h6d,
	parameter int UNIT = `RSC_UNIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// decoded command stream
	input wire logic cmdValid,
	input wire rsc_cmd_type cmdCode,
	input wire logic cmdFirst,
	input wire logic cmdLast,
	input wire logic [31:0] cmdName,
	input wire logic [1:0] cmdDims,
	input wire logic [FW-1:0] cmdLo1,
	input wire logic [FW-1:0] cmdLo2,
	input wire logic [FW-1:0] cmdLo3,
	input wire logic [FW-1:0] cmdHi1,
	input wire logic [FW-1:0] cmdHi2,
	input wire logic [FW-1:0] cmdHi3,
	input wire logic [15:0] cmdValue,
	output logic cmdReady,
	// backplane trigger lines
	input wire logic [7:0] ttlTrig,
	output logic [7:0] trigOut,
	// relay drive and answers
	output logic [NMOD*NREL-1:0] relayClosed,
	output logic queryValid,
	output logic queryBit,
	output logic errorFlag,
	output logic scanActive
);
	localparam int MW = (NMOD > 1) ? $clog2(NMOD) : 1;
	localparam int IW = $clog2(NREL);
	localparam int AW = MW + IW;
	localparam int LW = $clog2(DEPTH + 1);

	typedef struct packed {
		rsc_walk_type walk;
		rsc_cmd_type cmd;
		logic last;
		logic bad;
		logic [MW-1:0] mod;
		logic [FW-1:0] lo1, lo2, lo3, hi1, hi2, hi3, cur1, cur2, cur3;
		logic [NMOD*NREL-1:0] relay;
		logic [NMOD*NREL-1:0] pend;
		logic [NMOD-1:0][31:0] names;
		logic [DEPTH-1:0][AW-1:0] list;
		logic [LW-1:0] len, pendLen, pos;
		rsc_scan_type scan;
		logic started, tmrAGo, tmrAStop, tmrBGo, tmrBStop;
		rsc_src_type src;
		logic [2:0] ttlSel;
		logic [7:0] ttlPrev, outEn, trigOut;
		logic [15:0] delay, openDw, closeDw, tmrBLoad;
		logic qValid, qBit, err, ready, active;
	} rsc_state_type;

	function automatic logic [NMOD-1:0][31:0] defNames();
		logic [NMOD-1:0][31:0] t;
		for (int i = 0; i < NMOD; i++) begin
			t[i] = {16'h0000, `RSC_NAME_M, `RSC_DIGIT_1 + 8'(i)};
		end
		return t;
	endfunction : defNames

	function automatic logic [MW:0] findMod(
		input logic [NMOD-1:0][31:0] tbl, input logic [31:0] nm);
		logic [MW:0] r;
		r = '0;
		for (int i = NMOD - 1; i >= 0; i--) begin
			if (tbl[i] == nm) begin
				r = {1'b1, MW'(i)};
			end
		end
		return r;
	endfunction : findMod

	// unused dimensions arrive as 1
	function automatic logic fieldsOk(input logic [1:0] d,
		input logic [FW-1:0] f1, f2, f3);
		logic ok;
		ok = f1 != 0 && f2 != 0 && f3 != 0;
		case (d)
			2'h1: ok = ok && f1 <= NREL;
			2'h2: ok = ok && f1 <= SEC && f2 <= NREL / SEC;
			2'h3: ok = ok && f1 <= ROWS && f2 <= COLS &&
				f3 <= NREL / (ROWS * COLS);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : fieldsOk

	function automatic logic [IW-1:0] relayIdx(input logic [1:0] d,
		input logic [FW-1:0] f1, f2, f3);
		int v;
		case (d)
			2'h2: v = (int'(f2) - 1) * SEC + int'(f1) - 1;
			2'h3: v = ((int'(f3) - 1) * COLS + int'(f2) - 1) * ROWS +
				int'(f1) - 1;
			default: v = int'(f1) - 1;
		endcase
		return IW'(v);
	endfunction : relayIdx

	localparam logic [NMOD-1:0][31:0] DEF_NAMES = defNames();

	rsc_state_type st, next_st;
	logic take, trigEvt, forceEvt, tmrADone, tmrBDone, accept, entryOk;
	logic aliasOk, finish, atEnd;
	logic [MW:0] hit, aliasHit;
	logic [1:0] modDims;
	logic [FW-1:0] eLo2, eLo3, eHi2, eHi3;
	logic [7:0] ttlRise;
	logic [AW-1:0] curEntry, walkIdx;
	logic [MW:0] slot;

	assign take = cmdValid && st.ready;
	assign forceEvt = take && cmdCode == CMD_FORCE;
	assign trigEvt = take && (cmdCode == CMD_BUS_TRIG ||
		cmdCode == CMD_COMMON_TRIGGER_COMMAND);
	assign ttlRise = ttlTrig & ~st.ttlPrev;
	assign hit = findMod(st.names, cmdName);
	assign modDims = MOD_DIMS[2*hit[MW-1:0] +: 2];
	assign eLo2 = cmdDims >= 2'h2 ? cmdLo2 : FW'(1);
	assign eHi2 = cmdDims >= 2'h2 ? cmdHi2 : FW'(1);
	assign eLo3 = cmdDims == 2'h3 ? cmdLo3 : FW'(1);
	assign eHi3 = cmdDims == 2'h3 ? cmdHi3 : FW'(1);
	assign entryOk = hit[MW] && cmdDims == modDims &&
		fieldsOk(cmdDims, cmdLo1, eLo2, eLo3) &&
		fieldsOk(cmdDims, cmdHi1, eHi2, eHi3) &&
		cmdLo1 <= cmdHi1 && eLo2 <= eHi2 && eLo3 <= eHi3;
	assign slot = (MW+1)'(cmdValue - 16'h0001);
	assign aliasHit = hit;
	assign aliasOk = cmdValue != 0 && cmdValue <= NMOD && cmdName != 0 &&
		(!aliasHit[MW] || aliasHit[MW-1:0] == slot[MW-1:0]);
	assign accept = st.src == SRC_IMM || (st.src == SRC_BUS && trigEvt) ||
		(st.src == SRC_TTL && ttlRise[st.ttlSel]);
	assign curEntry = st.list[st.pos];
	assign walkIdx = {st.mod, relayIdx(2'(MOD_DIMS[2*st.mod +: 2]),
		st.cur1, st.cur2, st.cur3)};
	assign atEnd = st.cur1 == st.hi1 && st.cur2 == st.hi2 &&
		st.cur3 == st.hi3;

	always_comb begin
		next_st = st;
		finish = 1'b0;
		next_st.tmrAGo = 1'b0;
		next_st.tmrAStop = 1'b0;
		next_st.tmrBGo = 1'b0;
		next_st.tmrBStop = 1'b0;
		next_st.qValid = 1'b0;
		next_st.trigOut = 8'h00;
		next_st.ttlPrev = ttlTrig;
		////////////////////////////////////////////////////////////////
		// scan sequencer
		case (st.scan)
			S_ARMED: begin
				if (forceEvt) begin
					next_st.scan = st.started ? S_OPEN : S_CLOSE;
				end else if (accept) begin
					next_st.scan = S_DELAY;
					next_st.tmrBGo = 1'b1;
					next_st.tmrBLoad = st.delay;
				end
			end
			S_DELAY: begin
				if (tmrBDone) begin
					next_st.scan = st.started ? S_OPEN : S_CLOSE;
				end
			end
			S_OPEN: begin
				next_st.relay[curEntry] = 1'b0;
				next_st.pos = st.pos + 1'b1;
				next_st.tmrBGo = 1'b1;
				next_st.tmrBLoad = st.openDw;
				next_st.scan = S_OPEN_WAIT;
			end
			S_OPEN_WAIT: begin
				if (tmrBDone) begin
					next_st.scan = S_CLOSE;
				end
			end
			S_CLOSE: begin
				next_st.relay[curEntry] = 1'b1;
				next_st.started = 1'b1;
				next_st.tmrBGo = 1'b1;
				next_st.tmrBLoad = st.closeDw;
				next_st.scan = S_CLOSE_WAIT;
			end
			S_CLOSE_WAIT: begin
				if (tmrBDone) begin
					next_st.trigOut = st.outEn;
					next_st.scan = (st.pos == st.len - 1'b1) ? S_IDLE : S_ARMED;
				end
			end
			default: ;
		endcase
		////////////////////////////////////////////////////////////////
		// commands
		if (take) begin
			case (cmdCode)
				CMD_CLOSE, CMD_CLOSE_Q, CMD_SCAN: begin
					if (cmdFirst) begin
						next_st.bad = 1'b0;
						next_st.pend = '0;
						next_st.pendLen = '0;
					end
					next_st.cmd = cmdCode;
					next_st.last = cmdLast;
					next_st.mod = hit[MW-1:0];
					next_st.lo1 = cmdLo1;
					next_st.lo2 = eLo2;
					next_st.lo3 = eLo3;
					next_st.hi1 = cmdHi1;
					next_st.hi2 = eHi2;
					next_st.hi3 = eHi3;
					next_st.cur1 = cmdLo1;
					next_st.cur2 = eLo2;
					next_st.cur3 = eLo3;
					// a new list may not replace one being stepped
					if (entryOk && !(cmdCode == CMD_SCAN && st.scan != S_IDLE)) begin
						next_st.walk = W_RUN;
					end else begin
						next_st.bad = 1'b1;
						finish = cmdLast;
					end
				end
				CMD_ALIAS: begin
					if (aliasOk) begin
						next_st.names[slot[MW-1:0]] = cmdName;
					end else begin
						next_st.err = 1'b1;
					end
				end
				CMD_ABORT: begin
					next_st.scan = S_IDLE;
					next_st.tmrBStop = 1'b1;
				end
				CMD_INIT: begin
					if (st.len != 0) begin
						next_st.scan = S_ARMED;
						next_st.pos = '0;
						next_st.started = 1'b0;
						next_st.tmrBStop = 1'b1;
					end
				end
				CMD_SOURCE: begin
					next_st.src = rsc_src_type'(cmdValue[`RSC_SRC_LSB +: 2]);
					next_st.ttlSel = cmdValue[`RSC_LINE_LSB +: 3];
				end
				CMD_DELAY: next_st.delay = cmdValue;
				CMD_OPEN_DWELL: next_st.openDw = cmdValue;
				CMD_CLOSE_DWELL: next_st.closeDw = cmdValue;
				CMD_TTL_OUT: next_st.outEn = cmdValue[7:0];
				CMD_CLR_ERR: next_st.err = 1'b0;
				default: ;
			endcase
		end
		////////////////////////////////////////////////////////////////
		// channel list walker, one relay per cycle
		case (st.walk)
			W_RUN: begin
				case (st.cmd)
					CMD_CLOSE: next_st.pend[walkIdx] = 1'b1;
					CMD_CLOSE_Q: begin
						next_st.qValid = 1'b1;
						next_st.qBit = st.relay[walkIdx];
					end
					default: begin
						if (st.pendLen == LW'(DEPTH)) begin
							next_st.bad = 1'b1;
						end else begin
							next_st.list[st.pendLen] = walkIdx;
							next_st.pendLen = st.pendLen + 1'b1;
						end
					end
				endcase
				if (st.cur1 != st.hi1) begin
					next_st.cur1 = st.cur1 + 1'b1;
				end else begin
					next_st.cur1 = st.lo1;
					if (st.cur2 != st.hi2) begin
						next_st.cur2 = st.cur2 + 1'b1;
					end else begin
						next_st.cur2 = st.lo2;
						next_st.cur3 = st.cur3 + 1'b1;
					end
				end
				if (atEnd) begin
					next_st.walk = W_IDLE;
					finish = st.last;
				end
			end
			W_SETTLE: begin
				if (tmrADone) begin
					next_st.trigOut = next_st.trigOut | st.outEn;
					next_st.walk = W_IDLE;
				end
			end
			default: ;
		endcase
		if (finish) begin
			if (next_st.bad) begin
				next_st.err = 1'b1;
				if (next_st.cmd == CMD_SCAN && st.scan == S_IDLE) begin
					next_st.len = '0;
				end
			end else if (next_st.cmd == CMD_CLOSE) begin
				next_st.relay = next_st.relay | st.pend |
					(st.walk == W_RUN ? next_st.pend : '0);
				next_st.walk = W_SETTLE;
				next_st.tmrAGo = 1'b1;
			end else if (next_st.cmd == CMD_SCAN) begin
				next_st.len = next_st.pendLen;
			end
		end
		if (take && cmdCode == CMD_RESET) begin
			next_st.relay = '0;
			next_st.pend = '0;
			next_st.scan = S_IDLE;
			next_st.walk = W_IDLE;
			next_st.tmrAStop = 1'b1;
			next_st.tmrBStop = 1'b1;
			next_st.delay = `RSC_DWELL_RST;
			next_st.openDw = `RSC_DWELL_RST;
			next_st.closeDw = `RSC_DWELL_RST;
			next_st.outEn = 8'h00;
			next_st.src = SRC_IMM;
		end
		next_st.ready = next_st.walk == W_IDLE;
		next_st.active = next_st.scan != S_IDLE;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.names <= DEF_NAMES;
			st.ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	rsc_dwell_timer #(.UNIT(UNIT), .VW(16)) settleTimer (
		.clk(clk),
		.srst(srst),
		.start(st.tmrAGo),
		.cancel(st.tmrAStop),
		.load(st.closeDw),
		.done(tmrADone)
	);

	rsc_dwell_timer #(.UNIT(UNIT), .VW(16)) scanTimer (
		.clk(clk),
		.srst(srst),
		.start(st.tmrBGo),
		.cancel(st.tmrBStop),
		.load(st.tmrBLoad),
		.done(tmrBDone)
	);

	assign cmdReady = st.ready;
	assign trigOut = st.trigOut;
	assign relayClosed = st.relay;
	assign queryValid = st.qValid;
	assign queryBit = st.qBit;
	assign errorFlag = st.err;
	assign scanActive = st.active;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_abort_idle: assert property (take && cmdCode == CMD_ABORT
		|=> st.scan == S_IDLE) else $error("abort left scan running");
	chk_idle_stays: assert property (st.scan == S_IDLE &&
		!(take && cmdCode == CMD_INIT) |=> st.scan == S_IDLE)
		else $error("idle scan moved without arm");
	chk_none_ignores: assert property (st.scan == S_ARMED &&
		st.src == SRC_NONE && !take |=> st.scan == S_ARMED)
		else $error("source none accepted a trigger");
	chk_force_skip: assert property (st.scan == S_ARMED && forceEvt
		|=> st.scan inside {S_OPEN, S_CLOSE})
		else $error("forced trigger waited on delay");
	chk_step_close: assert property (st.scan == S_CLOSE && !take
		|=> st.relay[$past(curEntry)] && st.scan == S_CLOSE_WAIT)
		else $error("scan step did not close relay");
	chk_reset_open: assert property (take && cmdCode == CMD_RESET
		|=> st.relay == '0 && st.closeDw == '0)
		else $error("reset left a relay closed");
	chk_query_bit: assert property (st.walk == W_RUN &&
		st.cmd == CMD_CLOSE_Q |=> queryValid &&
		queryBit == $past(st.relay[walkIdx]))
		else $error("query bit disagrees with relay");
	chk_settle_out: assert property (st.walk == W_SETTLE && tmrADone
		|=> trigOut == $past(st.outEn) && cmdReady)
		else $error("settle end did not pulse triggers");
	chk_settle_hold: assert property (st.walk == W_SETTLE
		|-> !cmdReady) else $error("command taken during settle");
	chk_bad_entry: assert property (take && st.scan == S_IDLE &&
		cmdCode == CMD_CLOSE && !entryOk && cmdLast
		|=> st.relay == $past(st.relay) && errorFlag)
		else $error("bad list changed relays");

	cov_scan_step: cover property (st.scan == S_OPEN ##[1:300]
		st.scan == S_CLOSE_WAIT);
	cov_query: cover property (queryValid ##1 queryValid);
	cov_force_none: cover property (st.src == SRC_NONE && forceEvt &&
		st.scan == S_ARMED);
endmodule : rsc_scan_ctrl
`default_nettype wire

// ---- rsc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module rsc_host_model
	import rsc_pkg::*;
#(
	parameter int FW = 9
) (
	// clock and answers
	input wire logic clk,
	input wire logic cmdReady,
	input wire logic queryValid,
	input wire logic queryBit,
	// command stream
	output var logic cmdValid,
	output var rsc_cmd_type cmdCode,
	output var logic cmdFirst,
	output var logic cmdLast,
	output var logic [31:0] cmdName,
	output var logic [1:0] cmdDims,
	output var logic [FW-1:0] cmdLo1,
	output var logic [FW-1:0] cmdLo2,
	output var logic [FW-1:0] cmdLo3,
	output var logic [FW-1:0] cmdHi1,
	output var logic [FW-1:0] cmdHi2,
	output var logic [FW-1:0] cmdHi3,
	output var logic [15:0] cmdValue,
	// backplane trigger lines
	output var logic [7:0] ttlTrig
);
	logic qBits[$];
	initial begin
		{cmdFirst, cmdLast, cmdDims, cmdName, cmdValue} = '0;
		{cmdLo1, cmdLo2, cmdLo3, cmdHi1, cmdHi2, cmdHi3} = '0;
		cmdValid = 1'b0;
		cmdCode = CMD_NOP;
		ttlTrig = 8'h00;
	end
	////////////////////////////////
	always @(posedge clk) begin
		if (queryValid === 1'b1) begin
			qBits.push_back(queryBit);
		end
	end
	////////////////////////////////
	// entered just after an edge; holds everything until ready is sampled
	task automatic send(input rsc_cmd_type c, input logic [1:0] fl,
		input logic [31:0] n, input logic [1:0] d,
		input logic [3*FW-1:0] lo, input logic [3*FW-1:0] hi,
		input logic [15:0] v);
		int k;
		cmdCode = c;
		{cmdFirst, cmdLast} = fl;
		cmdName = n;
		cmdDims = d;
		{cmdLo3, cmdLo2, cmdLo1} = lo;
		{cmdHi3, cmdHi2, cmdHi1} = hi;
		cmdValue = v;
		cmdValid = 1'b1;
		k = 0;
		do @(negedge clk); while (!cmdReady && ++k < 5000);
		@(posedge clk);
		#1;
		cmdValid = 1'b0;
		// released field, name and value lines invert, so a stale value never matches by luck
		{cmdLo1, cmdLo2, cmdLo3} = ~{cmdLo1, cmdLo2, cmdLo3};
		{cmdHi1, cmdHi2, cmdHi3} = ~{cmdHi1, cmdHi2, cmdHi3};
		cmdName = ~cmdName;
		cmdValue = ~cmdValue;
		@(posedge clk);
		#1;
	endtask : send
	task automatic wait_rdy();
		int k;
		k = 0;
		do @(negedge clk); while (!cmdReady && ++k < 5000);
		repeat (3) @(posedge clk);
		#1;
	endtask : wait_rdy
	task automatic ttl_pulse(input logic [7:0] m);
		ttlTrig = m;
		repeat (2) @(posedge clk);
		#1;
		ttlTrig = 8'h00;
	endtask : ttl_pulse
endmodule : rsc_host_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench
	import rsc_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cmdValid, cmdFirst, cmdLast, cmdReady, queryValid, queryBit;
	logic errorFlag, scanActive;
	rsc_cmd_type cmdCode;
	logic [31:0] cmdName;
	logic [1:0] cmdDims;
	logic [8:0] cmdLo1, cmdLo2, cmdLo3, cmdHi1, cmdHi2, cmdHi3;
	logic [15:0] cmdValue;
	logic [7:0] ttlTrig, trigOut;
	logic [1023:0] relayClosed, snap;
	int n_fail = 0;
	int n_tests = 0;
	always #50 clk = ~clk;
	////////////////////////////////
	rsc_scan_ctrl #(.UNIT(2)) u_rsc_scan_ctrl (
		.clk, .srst, .cmdValid, .cmdCode, .cmdFirst, .cmdLast, .cmdName,
		.cmdDims, .cmdLo1, .cmdLo2, .cmdLo3, .cmdHi1, .cmdHi2, .cmdHi3,
		.cmdValue, .cmdReady, .ttlTrig, .trigOut, .relayClosed,
		.queryValid, .queryBit, .errorFlag, .scanActive
	);
	rsc_host_model u_rsc_host_model (
		.clk, .cmdReady, .queryValid, .queryBit, .cmdValid, .cmdCode,
		.cmdFirst, .cmdLast, .cmdName, .cmdDims, .cmdLo1, .cmdLo2,
		.cmdLo3, .cmdHi1, .cmdHi2, .cmdHi3, .cmdValue, .ttlTrig
	);
	////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t ns: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	function automatic logic [31:0] nm(input int i);
		return 32'h00006d30 + i[31:0];
	endfunction : nm
	function automatic logic [26:0] rn(input int a, input int b, input int c);
		return {c[8:0], b[8:0], a[8:0]};
	endfunction : rn
	task automatic ent(input rsc_cmd_type c, input logic [1:0] fl,
		input logic [31:0] n, input logic [1:0] d,
		input logic [26:0] lo, input logic [26:0] hi);
		u_rsc_host_model.send(c, fl, n, d, lo, hi, 16'h0000);
	endtask : ent
	task automatic op(input rsc_cmd_type c, input logic [31:0] n,
		input logic [15:0] v);
		u_rsc_host_model.send(c, 2'b00, n, 2'h0, '0, '0, v);
	endtask : op
	task automatic poll(input int b);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			#1;
		end while (relayClosed[b] !== 1'b1 && ++k < 200);
		// let the close settle end so the scan is armed again
		repeat (4) @(posedge clk);
		#1;
	endtask : poll
	////////////////////////////////
	task automatic t_reset();
		check(|relayClosed, 1'b0);
		check(cmdReady, 1'b1);
	endtask : t_reset
	task automatic t_close();
		ent(CMD_CLOSE, 2'b10, nm(1), 2'h1, rn(1, 0, 0), rn(2, 0, 0));
		ent(CMD_CLOSE, 2'b00, nm(3), 2'h2, rn(4, 8, 0), rn(4, 8, 0));
		ent(CMD_CLOSE, 2'b01, nm(2), 2'h3, rn(3, 16, 4), rn(3, 16, 4));
		u_rsc_host_model.wait_rdy();
		check(relayClosed[3:0], 4'h3);
		check(relayClosed[627], 1'b1);
		check(relayClosed[510], 1'b1);
		check(errorFlag, 1'b0);
	endtask : t_close
	task automatic t_query();
		u_rsc_host_model.qBits.delete();
		ent(CMD_CLOSE_Q, 2'b11, nm(1), 2'h1, rn(1, 0, 0), rn(4, 0, 0));
		u_rsc_host_model.wait_rdy();
		check(u_rsc_host_model.qBits.size(), 4);
		check({u_rsc_host_model.qBits[0], u_rsc_host_model.qBits[1],
			u_rsc_host_model.qBits[2], u_rsc_host_model.qBits[3]}, 4'hc);
	endtask : t_query
	task automatic t_alias();
		op(CMD_ALIAS, 32'h00007266, 16'h0003);
		ent(CMD_CLOSE, 2'b11, 32'h00007266, 2'h2, rn(3, 2, 0), rn(3, 2, 0));
		u_rsc_host_model.wait_rdy();
		check(relayClosed[530], 1'b1);
	endtask : t_alias
	task automatic t_bad();
		snap = relayClosed;
		// good entry first: the whole list must still be thrown away
		ent(CMD_CLOSE, 2'b10, nm(1), 2'h1, rn(9, 0, 0), rn(9, 0, 0));
		ent(CMD_CLOSE, 2'b01, nm(9), 2'h1, rn(1, 0, 0), rn(1, 0, 0));
		u_rsc_host_model.wait_rdy();
		check(relayClosed === snap, 1'b1);
		check(errorFlag, 1'b1);
		op(CMD_CLR_ERR, 32'h0, 16'h0000);
		check(errorFlag, 1'b0);
		ent(CMD_CLOSE, 2'b11, nm(1), 2'h1, rn(7, 0, 0), rn(5, 0, 0));
		u_rsc_host_model.wait_rdy();
		check(relayClosed === snap, 1'b1);
		check(errorFlag, 1'b1);
		op(CMD_CLR_ERR, 32'h0, 16'h0000);
	endtask : t_bad
	task automatic t_settle();
		int k;
		op(CMD_CLOSE_DWELL, nm(4), 16'h0005);
		op(CMD_TTL_OUT, 32'h0, 16'h0001);
		ent(CMD_CLOSE, 2'b11, nm(4), 2'h1, rn(1, 0, 0), rn(1, 0, 0));
		for (k = 0; k < 300 && trigOut === 8'h00; k++) @(negedge clk);
		check(trigOut, 8'h01);
		check(k >= 10, 1'b1);
		check(relayClosed[768], 1'b1);
		u_rsc_host_model.wait_rdy();
	endtask : t_settle
	task automatic t_reset_cmd();
		op(CMD_RESET, 32'h0, 16'h0000);
		u_rsc_host_model.wait_rdy();
		check(|relayClosed, 1'b0);
	endtask : t_reset_cmd
	task automatic t_scan();
		ent(CMD_SCAN, 2'b11, nm(1), 2'h1, rn(5, 0, 0), rn(7, 0, 0));
		op(CMD_SOURCE, 32'h0, 16'h0001);
		op(CMD_DELAY, 32'h0, 16'h0003);
		op(CMD_INIT, 32'h0, 16'h0000);
		check(scanActive, 1'b1);
		op(CMD_BUS_TRIG, 32'h0, 16'h0000);
		op(CMD_COMMON_TRIGGER_COMMAND, 32'h0, 16'h0000);
		u_rsc_host_model.ttl_pulse(8'hff);
		repeat (20) @(posedge clk);
		#1;
		check(relayClosed[6:4], 3'h0);
		op(CMD_FORCE, 32'h0, 16'h0000);
		// delay of 3 units would hold the close back for six cycles
		check(relayClosed[4], 1'b1);
		poll(4);
		check(relayClosed[6:4], 3'h1);
		op(CMD_FORCE, 32'h0, 16'h0000);
		poll(5);
		check(relayClosed[6:4], 3'h2);
		op(CMD_ABORT, 32'h0, 16'h0000);
		check(scanActive, 1'b0);
		op(CMD_FORCE, 32'h0, 16'h0000);
		op(CMD_BUS_TRIG, 32'h0, 16'h0000);
		repeat (20) @(posedge clk);
		#1;
		check(relayClosed[6:4], 3'h2);
		// re-arm from open relays: bus, line and immediate sources
		op(CMD_RESET, 32'h0, 16'h0000);
		op(CMD_SOURCE, 32'h0, 16'h0002);
		op(CMD_DELAY, 32'h0, 16'h0003);
		op(CMD_INIT, 32'h0, 16'h0000);
		op(CMD_BUS_TRIG, 32'h0, 16'h0000);
		repeat (4) @(posedge clk);
		#1;
		check(relayClosed[4], 1'b0);
		poll(4);
		check(relayClosed[6:4], 3'h1);
		op(CMD_SOURCE, 32'h0, 16'h000b);
		u_rsc_host_model.ttl_pulse(8'h04);
		poll(5);
		check(relayClosed[6:4], 3'h2);
		op(CMD_SOURCE, 32'h0, 16'h0000);
		poll(6);
		check(relayClosed[6:4], 3'h4);
		check(scanActive, 1'b0);
	endtask : t_scan
	////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		#1;
		t_reset();
		srst = 1'b0;
		t_close();
		t_query();
		t_alias();
		t_bad();
		t_settle();
		t_reset_cmd();
		t_scan();
		finish_test();
	end
	initial begin
		#(20000 * 100);
		n_fail++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
